// ===== logic/reset_sequencer.sv
// Reset sequencer: merges reset sources, holds the core and launches initialisation.
// Summary of operation
// - Reset is entered from pin low, power-on, watchdog timeout or low voltage.
// - Reset pin is active low; reset holds while pin low in any mode.
// - Pin reset is stretched by a delay so short pulses still reset fully.
// - Pin reset in run or wait stops execution, pulls up I/O, restarts oscillator.
// - Initialisation begins only after the internal delay expires once the pin is high.
// - Pin reset in stop mode starts the oscillator and pulls up I/O before release.
// - Power-on holds reset, starts oscillator, waits stabilisation, then initialises.
// - Watchdog end-of-count resets the device and reinitialises the watchdog counter.
// - Watchdog reset restarts like a pin reset, with the same stabilisation delay.
// - With the low-voltage option on, reset holds while supply is below reference.
// - Internal reset sources drive the reset pin low, open-drain.
// - Every reset clears the stack and loads the reset vector into the program counter.
// - After reset the core runs in non-maskable interrupt context.
// - Interrupt return ends that context, enables interrupts, pending ones served first.
// - Any reset clears the main oscillator off bit.
// - Reset loads the watchdog register with its all-ones-except-bit-0 value.
`timescale 1ns/1ps
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int STAB_CYCLES = STAB_DELAY_CYCLES,
  parameter int STRETCH_CYCLES = PULSE_STRETCH_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic reset_pin_in,
  input wire logic power_on_detect,
  input wire logic watchdog_end_count,
  input wire logic low_voltage_detect,
  input wire logic low_voltage_option,
  input wire power_mode_t power_mode,
  input wire logic return_from_interrupt,
  input wire logic interrupt_pending,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output reset_controls_t controls,
  output logic [PC_WIDTH-1:0] reset_pc,
  output logic [7:0] watchdog_register,
  output logic nmi_context,
  output logic interrupts_enabled,
  output logic take_pending_interrupt,
  output logic init_start,
  output logic stop_exit
);
  // ************************************************************
  // Input synchronisation
  // ************************************************************
  // The pin and the analogue detectors are asynchronous; each crosses two flops.
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  wire [3:0] raw_inputs = {reset_pin_in, power_on_detect, watchdog_end_count, low_voltage_detect};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
    end else if (clock_enable) begin
      sync_a <= raw_inputs;
      sync_b <= sync_a;
    end
  end

  // ************************************************************
  // Source decoding
  // ************************************************************
  wire pin_low = !sync_b[3];
  reset_sources_t sources;
  assign sources.pin = pin_low;
  assign sources.power_on = sync_b[2];
  assign sources.watchdog = sync_b[1];
  assign sources.low_voltage = sync_b[0] && low_voltage_option;

  // Short pin pulses are stretched so that the delay always runs its full length.
  localparam int SW = $clog2(STRETCH_CYCLES + 1);
  logic [SW-1:0] stretch;
  wire stretch_busy = (stretch != '0);
  wire [SW-1:0] next_stretch = pin_low ? SW'(STRETCH_CYCLES) : (stretch_busy ? SW'(stretch - 1'b1) : stretch);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stretch <= '0;
    end else if (clock_enable) begin
      stretch <= next_stretch;
    end
  end

  wire internal_source = sources.power_on || sources.watchdog || sources.low_voltage;
  wire any_source = sources.pin || stretch_busy || internal_source;

  // ************************************************************
  // Sequencer state machine
  // ************************************************************
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_INIT,
    ST_RUN
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  wire delay_done;

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!any_source) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (any_source) begin
          next_state = ST_HOLD;
        end else if (delay_done) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        next_state = any_source ? ST_HOLD : ST_RUN;
      end
      ST_RUN: begin
        if (any_source) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  stab_counter #(
    .COUNT(STAB_CYCLES)
  ) delay_counter (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .restart(state != ST_DELAY),
    .expired(delay_done)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_HOLD;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  wire in_reset = (next_state == ST_HOLD) || (next_state == ST_DELAY);
  wire stop_wake = any_source && (power_mode == MODE_STOP);
  wire return_taken = nmi_context && return_from_interrupt && (state == ST_RUN);
  wire init_pulse = (next_state == ST_INIT);
  wire next_nmi = init_pulse ? 1'b1 : (return_taken ? 1'b0 : nmi_context);
  wire next_ie = init_pulse ? 1'b0 : (return_taken ? 1'b1 : interrupts_enabled);
  wire [7:0] next_wd = in_reset ? WATCHDOG_RESET_VALUE : watchdog_register;

  reset_controls_t next_controls;
  assign next_controls.core_hold = in_reset;
  assign next_controls.io_pullup_inputs = in_reset;
  assign next_controls.osc_enable = in_reset || (power_mode != MODE_STOP);
  assign next_controls.main_osc_off_bit_clear = in_reset;
  assign next_controls.watchdog_load = in_reset;
  assign next_controls.stack_clear = in_reset;
  assign next_controls.pc_load = in_reset || init_pulse;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      controls <= '1;
      reset_pc <= RESET_VECTOR;
      watchdog_register <= WATCHDOG_RESET_VALUE;
      nmi_context <= 1'b1;
      interrupts_enabled <= 1'b0;
      take_pending_interrupt <= 1'b0;
      init_start <= 1'b0;
      stop_exit <= 1'b0;
    end else if (clock_enable) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !internal_source;
      controls <= next_controls;
      reset_pc <= RESET_VECTOR;
      watchdog_register <= next_wd;
      nmi_context <= next_nmi;
      interrupts_enabled <= next_ie;
      take_pending_interrupt <= return_taken && interrupt_pending;
      init_start <= init_pulse;
      stop_exit <= stop_wake;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Held-off checks use the internal state, since outputs lag by one cycle.
  pin_holds_core_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && pin_low) |=> controls.core_hold)
    else $error("Core not held while reset pin low.");

  internal_drives_pin_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && internal_source) |=> !reset_pin_oe_n)
    else $error("Reset pin not pulled low for internal source.");

  pin_released_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && !internal_source) |=> reset_pin_oe_n)
    else $error("Reset pin driven with no internal source.");

  source_priority_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && any_source) |=> (state == ST_HOLD))
    else $error("Active source did not force hold.");

  init_after_delay_a: assert property (
    @(posedge clock) disable iff (rst) (init_start && $past(clock_enable)) |-> ($past(state) == ST_DELAY))
    else $error("Initialisation started without the delay.");

  init_sets_nmi_a: assert property (
    @(posedge clock) disable iff (rst) init_start |-> (nmi_context && !interrupts_enabled))
    else $error("Initialisation not in non-maskable context.");

  return_enables_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && return_taken && !init_pulse)
      |=> (interrupts_enabled && !nmi_context))
    else $error("Interrupt return did not restore normal mode.");

  watchdog_reload_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && in_reset) |=> (watchdog_register == 8'hFE))
    else $error("Watchdog register not reloaded in reset.");

  vector_loaded_a: assert property (
    @(posedge clock) disable iff (rst) init_start |-> (reset_pc == 12'hFFE && controls.pc_load))
    else $error("Reset vector not loaded at initialisation.");

  low_voltage_hold_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && sync_b[0] && low_voltage_option) |=> controls.core_hold)
    else $error("Low voltage did not hold reset.");

  stretch_reload_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && pin_low)
      |=> (stretch == SW'(STRETCH_CYCLES)))
    else $error("Pulse stretch not reloaded while pin low.");

  stretch_count_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && stretch_busy && !pin_low)
      |=> (SW'(stretch + 1'b1) == $past(stretch)))
    else $error("Pulse stretch did not count down.");

  delay_entry_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && state == ST_HOLD && !any_source)
      |=> (state == ST_DELAY))
    else $error("Delay did not start after sources cleared.");

  delay_expiry_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && state == ST_DELAY && delay_done && !any_source)
      |=> init_start)
    else $error("Initialisation not started when delay expired.");

  init_single_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && init_start)
      |=> !init_start)
    else $error("Initialisation pulse lasted more than one cycle.");

  core_release_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && state == ST_RUN && !any_source)
      |=> !controls.core_hold)
    else $error("Core held with no reset source.");

  osc_restart_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && any_source)
      |=> (controls.osc_enable && controls.main_osc_off_bit_clear))
    else $error("Oscillator not restarted in reset.");

  pullup_hold_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && any_source)
      |=> (controls.io_pullup_inputs && controls.core_hold))
    else $error("Pins not pulled up while held in reset.");

  stop_wake_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && any_source && power_mode == MODE_STOP)
      |=> (stop_exit && controls.osc_enable))
    else $error("Stop mode reset did not wake the oscillator.");

  stack_cleared_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && any_source)
      |=> (controls.stack_clear && controls.pc_load))
    else $error("Stack not cleared in reset.");

  watchdog_reinit_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && sources.watchdog)
      |=> (controls.watchdog_load && controls.core_hold))
    else $error("Watchdog timeout did not reset and reload.");

  power_on_hold_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && sources.power_on)
      |=> (controls.core_hold && !init_start))
    else $error("Power-on did not hold reset.");

  supply_low_pin_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && sources.low_voltage)
      |=> (state == ST_HOLD && !reset_pin_oe_n))
    else $error("Low supply did not hold reset and pull the pin.");

  pending_served_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && return_taken && interrupt_pending)
      |=> take_pending_interrupt)
    else $error("Pending interrupt not served on return.");

  return_once_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && return_from_interrupt && !nmi_context)
      |=> !take_pending_interrupt)
    else $error("Later interrupt return had an effect.");

  nmi_hold_a: assert property (
    @(posedge clock) disable iff (rst) (clock_enable && nmi_context && !return_from_interrupt)
      |=> nmi_context)
    else $error("Non-maskable context left without a return.");
endmodule : reset_sequencer

// ===== logic/reset_seq_pkg.sv
// Package of constants and carrier types for the reset sequencer.
package reset_seq_pkg;
  // ************************************************************
  // Timing and reset values
  // ************************************************************
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int STAB_DELAY_NS = 20000;
  localparam int STAB_DELAY_CYCLES = (STAB_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PULSE_STRETCH_NS = 64;
  localparam int PULSE_STRETCH_CYCLES = (PULSE_STRETCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [11:0] RESET_VECTOR = 12'hFFE;
  localparam logic [7:0] WATCHDOG_RESET_VALUE = 8'hFE;
  localparam int WATCHDOG_ENABLE_BIT = 0;
  localparam int WATCHDOG_SOFT_BIT = 1;
  localparam int STACK_DEPTH = 6;
  localparam int PC_WIDTH = 12;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } power_mode_t;

  typedef struct packed {
    logic pin;
    logic power_on;
    logic watchdog;
    logic low_voltage;
  } reset_sources_t;

  typedef struct packed {
    logic core_hold;
    logic io_pullup_inputs;
    logic osc_enable;
    logic main_osc_off_bit_clear;
    logic watchdog_load;
    logic stack_clear;
    logic pc_load;
  } reset_controls_t;
endpackage : reset_seq_pkg

// ===== logic/stab_counter.sv
// Stabilisation delay counter that runs while enabled and flags its expiry.
`timescale 1ns/1ps
module stab_counter
  import reset_seq_pkg::*;
#(
  parameter int COUNT = STAB_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic restart,
  output logic expired
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count;
  wire at_last = (count == LAST);
  wire [CW-1:0] next_count = restart ? '0 : (at_last ? count : CW'(count + 1'b1));
  wire next_expired = !restart && at_last;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      expired <= 1'b0;
    end else if (enable) begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule : stab_counter

// ===== tb/reset_board.sv
// Board reset circuit: push button with pull-up on the open-drain reset pin.
`timescale 1ns/1ps
module reset_board (
  input wire logic press_n,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  output logic reset_pin_in
);
  // The pull-up wins when nobody pulls, so a released line never keeps a stale low.
  assign reset_pin_in = press_n & (reset_pin_oe_n | reset_pin_out);
endmodule : reset_board

// ===== tb/test_reset_sequencer.sv
// Self-checking testbench for the reset sequencer.
`timescale 1ns/1ps
module test_reset_sequencer;
  import reset_seq_pkg::*;
  localparam int STAB = 8;
  logic clock = 0, rst = 1, press_n = 1, power_on_detect = 0, watchdog_end_count = 0;
  logic low_voltage_detect = 0, low_voltage_option = 0, return_from_interrupt = 0, interrupt_pending = 0;
  logic clock_enable = 1;
  power_mode_t power_mode = MODE_RUN;
  logic reset_pin_in, reset_pin_out, reset_pin_oe_n, nmi_context, interrupts_enabled;
  logic take_pending_interrupt, init_start, stop_exit;
  reset_controls_t controls;
  logic [11:0] reset_pc;
  logic [7:0] watchdog_register;
  int failures = 0, check_count = 0, n;

  always #2 clock = ~clock;

  reset_board u_board (.press_n(press_n), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
    .reset_pin_in(reset_pin_in));
  reset_sequencer #(.STAB_CYCLES(STAB), .STRETCH_CYCLES(2)) u_dut (.clock(clock), .rst(rst),
    .clock_enable(clock_enable), .reset_pin_in(reset_pin_in), .power_on_detect(power_on_detect),
    .watchdog_end_count(watchdog_end_count), .low_voltage_detect(low_voltage_detect),
    .low_voltage_option(low_voltage_option), .power_mode(power_mode),
    .return_from_interrupt(return_from_interrupt), .interrupt_pending(interrupt_pending),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .controls(controls), .reset_pc(reset_pc),
    .watchdog_register(watchdog_register), .nmi_context(nmi_context), .interrupts_enabled(interrupts_enabled),
    .take_pending_interrupt(take_pending_interrupt), .init_start(init_start), .stop_exit(stop_exit));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick

  // Counts cycles until the initialisation pulse; a hang ends the run.
  task automatic wait_init(output int cnt);
    cnt = 0;
    while (init_start !== 1'b1) begin
      tick(1);
      cnt++;
      if (cnt > 400) begin
        failures++;
        $display("Error init_start expected 1 seen 0");
        finish_test();
      end
    end
    check("delay", cnt >= STAB, 1);
    check("core_hold", controls.core_hold, 0);
    check("nmi_context", nmi_context, 1);
    check("interrupts_enabled", interrupts_enabled, 0);
    check("reset_pc", reset_pc, 12'hFFE);
    tick(1);
    check("init_start", init_start, 0);
  endtask : wait_init

  task automatic irq_return(input logic pend);
    interrupt_pending = pend;
    return_from_interrupt = 1;
    tick(1);
    return_from_interrupt = 0;
    check("take_pending", take_pending_interrupt, pend);
    check("nmi_context", nmi_context, 0);
    check("interrupts_enabled", interrupts_enabled, 1);
    tick(1);
    check("take_pending", take_pending_interrupt, 0);
  endtask : irq_return

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_power_on();
    check("controls", controls, 7'h7F);
    check("watchdog_register", watchdog_register, 8'hFE);
    check("reset_pin_oe_n", reset_pin_oe_n, 0);
    check("reset_pin_out", reset_pin_out, 0);
    rst = 0;
    power_on_detect = 1;
    tick(4);
    check("oe_n power_on", reset_pin_oe_n, 0);
    check("core_hold", controls.core_hold, 1);
    power_on_detect = 0;
    wait_init(n);
    irq_return(1'b1);
    irq_return(1'b0);
    check("interrupts_enabled after", interrupts_enabled, 1);
    $display("Test power_on done");
  endtask : t_power_on

  task automatic t_pin(input power_mode_t m, input int len);
    power_mode = m;
    tick(1);
    check("osc_enable idle", controls.osc_enable, m != MODE_STOP);
    press_n = 0;
    tick(len);
    press_n = 1;
    if (len < 3) tick(3 - len);
    check("controls pin", controls, 7'h7F);
    check("oe_n pin", reset_pin_oe_n, 1);
    check("stop_exit", stop_exit, m == MODE_STOP);
    power_mode = MODE_RUN;
    wait_init(n);
    irq_return(1'b0);
    $display("Test pin reset done");
  endtask : t_pin

  task automatic t_watchdog();
    press_n = 0;
    tick(1);
    press_n = 1;
    tick(6);
    watchdog_end_count = 1;
    tick(1);
    watchdog_end_count = 0;
    tick(2);
    check("oe_n watchdog", reset_pin_oe_n, 0);
    check("watchdog_load", controls.watchdog_load, 1);
    check("watchdog_register", watchdog_register, 8'hFE);
    wait_init(n);
    $display("Test watchdog done");
  endtask : t_watchdog

  // A pin pulse while the clock enable is low must leave no trace.
  task automatic t_freeze();
    clock_enable = 0;
    press_n = 0;
    tick(6);
    check("core_hold frozen", controls.core_hold, 0);
    check("init_start frozen", init_start, 0);
    press_n = 1;
    clock_enable = 1;
    tick(6);
    check("core_hold after freeze", controls.core_hold, 0);
    $display("Test freeze done");
  endtask : t_freeze

  task automatic t_low_voltage();
    low_voltage_detect = 1;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      check("core_hold low_voltage off", controls.core_hold, 0);
    end
    low_voltage_option = 1;
    tick(3);
    for (int i = 0; i < 20; i++) begin
      check("core_hold low_voltage", controls.core_hold, 1);
      check("oe_n low_voltage", reset_pin_oe_n, 0);
      tick(1);
    end
    low_voltage_detect = 0;
    wait_init(n);
    $display("Test low_voltage done");
  endtask : t_low_voltage

  initial begin
    tick(2);
    t_power_on();
    t_pin(MODE_RUN, 1);
    t_pin(MODE_WAIT, 30);
    t_pin(MODE_STOP, 5);
    t_watchdog();
    t_freeze();
    t_low_voltage();
    finish_test();
  end
endmodule : test_reset_sequencer
